// ===== gpc_consts.vh
`ifndef GPC_CONSTS_VH
`define GPC_CONSTS_VH

// register byte offsets within the 4 KB port window
`define GPC_OFF_DIR      12'h400
`define GPC_OFF_ISENSE   12'h404
`define GPC_OFF_IBOTH    12'h408
`define GPC_OFF_IEVENT   12'h40C
`define GPC_OFF_IMASK    12'h410
`define GPC_OFF_IRAW     12'h414
`define GPC_OFF_IMSK_ST  12'h418
`define GPC_OFF_ICLR     12'h41C
`define GPC_OFF_AFSEL    12'h420
`define GPC_OFF_DRV_LO   12'h500
`define GPC_OFF_DRV_MID  12'h504
`define GPC_OFF_DRV_HI   12'h508
`define GPC_OFF_ODRAIN   12'h50C
`define GPC_OFF_PULLUP   12'h510
`define GPC_OFF_PULLDN   12'h514
`define GPC_OFF_SLEW     12'h518
`define GPC_OFF_DEN      12'h51C
`define GPC_OFF_LOCK     12'h520
`define GPC_OFF_COMMIT   12'h524
`define GPC_OFF_ID_BASE  12'hFD0

// data window: offsets below this hit the masked data register
`define GPC_DATA_TOP_BIT 11:10

// identification word count: 8 peripheral then 4 cell
`define GPC_ID_WORDS     4'hC

// reset values
`define GPC_RST_ZERO     8'h00
`define GPC_RST_DRV_LO   8'hFF

// AXI responses
`define GPC_RESP_OKAY    2'b00
`define GPC_RESP_SLVERR  2'b10

`endif

// ===== gpc_irq_detect.v
`timescale 1ns/10ps
`include "gpc_consts.vh"

module gpc_irq_detect #(
    parameter W = 8
) (
    // clock and reset
    input  wire         core_clk_in,
    input  wire         rstn_in,
    // raw pins from outside
    input  wire [W-1:0] pin_in,
    // trigger settings
    input  wire [W-1:0] sense_in,
    input  wire [W-1:0] both_in,
    input  wire [W-1:0] event_in,
    // results
    output wire [W-1:0] level_out,
    output wire [W-1:0] cond_out
);

    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            reg  s1_r;
            reg  s2_r;
            reg  s3_r;
            reg  stab_r;
            wire chg;
            wire edge_hit;
            wire level_hit;

            // stage one feeds only stage two; a change counts once stages two and three agree
            always @(posedge core_clk_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    s1_r   <= 1'b0;
                    s2_r   <= 1'b0;
                    s3_r   <= 1'b0;
                    stab_r <= 1'b0;
                end else begin
                    s1_r <= pin_in[i];
                    s2_r <= s1_r;
                    s3_r <= s2_r;
                    if (s2_r == s3_r) begin
                        stab_r <= s3_r;
                    end
                end
            end

            assign chg       = (s2_r == s3_r) && (s3_r != stab_r);
            assign edge_hit  = both_in[i] ? chg : (chg && (s3_r == event_in[i]));
            assign level_hit = event_in[i] ? stab_r : ~stab_r;
            assign cond_out[i]  = sense_in[i] ? level_hit : edge_hit;
            assign level_out[i] = stab_r;
        end
    endgenerate

endmodule

// ===== gpc_port.v
`timescale 1ns/10ps
`include "gpc_consts.vh"

module gpc_port #(
    parameter       W         = 8,
    parameter [7:0] PROT_MASK = 8'h00,
    // lock key and ident words are arbitrary values
    parameter [31:0] LOCK_KEY  = 32'h0000_5A5A,
    parameter [63:0] PERIPH_ID = 64'h0000_0000_0000_0000,
    parameter [31:0] CELL_ID   = 32'h0000_0000
) (
    // clock and reset
    input  wire         core_clk_in,
    input  wire         rstn_in,
    // axi write address
    input  wire         s_axi_awvalid,
    output wire         s_axi_awready,
    input  wire [11:0]  s_axi_awaddr,
    // axi write data
    input  wire         s_axi_wvalid,
    output wire         s_axi_wready,
    input  wire [31:0]  s_axi_wdata,
    input  wire [3:0]   s_axi_wstrb,
    // axi write response
    output wire         s_axi_bvalid,
    input  wire         s_axi_bready,
    output wire [1:0]   s_axi_bresp,
    // axi read
    input  wire         s_axi_arvalid,
    output wire         s_axi_arready,
    input  wire [11:0]  s_axi_araddr,
    output wire         s_axi_rvalid,
    input  wire         s_axi_rready,
    output wire [31:0]  s_axi_rdata,
    output wire [1:0]   s_axi_rresp,
    // pins
    input  wire [W-1:0] pin_in,
    output wire [W-1:0] pin_out,
    output wire [W-1:0] pin_oe_n_out,
    // alternate function peripheral
    input  wire [W-1:0] alt_out_in,
    input  wire [W-1:0] alt_oe_in,
    output wire [W-1:0] alt_in_out,
    // pad control
    output wire [W-1:0] pull_up_out,
    output wire [W-1:0] pull_down_out,
    output wire [W-1:0] drive_low_out,
    output wire [W-1:0] drive_mid_out,
    output wire [W-1:0] drive_high_out,
    output wire [W-1:0] slew_out,
    output wire [W-1:0] digital_pad_enable_out,
    // interrupt
    output wire         irq_out
);

    // axi state
    reg          awready_r;
    reg          wready_r;
    reg          bvalid_r;
    reg          arready_r;
    reg          rvalid_r;
    reg  [31:0]  rdata_r;
    reg  [1:0]   rresp_r;
    reg  [1:0]   bresp_r;
    reg          aw_hold_r;
    reg          w_hold_r;
    reg  [11:0]  awaddr_r;
    reg  [7:0]   wdata_r;
    reg          wstrb_r;

    // port registers
    reg  [W-1:0] pin_value_reg_r;
    reg  [W-1:0] pin_direction_r;
    reg  [W-1:0] irq_sense_select_r;
    reg  [W-1:0] irq_both_edges_r;
    reg  [W-1:0] irq_event_polarity_r;
    reg  [W-1:0] irq_mask_r;
    reg  [W-1:0] irq_raw_status_r;
    reg  [W-1:0] alt_function_select_r;
    reg  [W-1:0] drive_low_select_r;
    reg  [W-1:0] drive_mid_select_r;
    reg  [W-1:0] drive_high_select_r;
    reg  [W-1:0] open_drain_select_r;
    reg  [W-1:0] pull_up_select_r;
    reg  [W-1:0] pull_down_select_r;
    reg  [W-1:0] slew_control_select_r;
    reg  [W-1:0] digital_pad_enable_r;
    reg          protect_lock_r;
    reg  [W-1:0] protect_commit_r;

    // pin side outputs
    reg  [W-1:0] pin_out_r;
    reg  [W-1:0] pin_oe_n_r;
    reg  [W-1:0] alt_in_r;
    reg          irq_r;

    wire [W-1:0] pin_level;
    wire [W-1:0] irq_cond;
    wire         wr_fire;
    wire         wen;
    wire [7:0]   wd;
    wire [11:0]  wa;
    wire [W-1:0] afsel_ok;
    wire [W-1:0] prot;
    wire [W-1:0] clr_bits;
    reg  [W-1:0] ris_nxt;
    reg  [W-1:0] drv_val;
    reg  [W-1:0] drv_en;
    reg  [7:0]   rd_byte;
    reg          rd_err;
    reg  [11:0]  id_off;
    reg  [7:0]   id_byte;

    // each process keeps its own loop index so no process retriggers another
    integer k, kc, kd;

    gpc_irq_detect #(
        .W (W)
    ) u_detect (
        .core_clk_in (core_clk_in),
        .rstn_in     (rstn_in),
        .pin_in      (pin_in),
        .sense_in    (irq_sense_select_r),
        .both_in     (irq_both_edges_r),
        .event_in    (irq_event_polarity_r),
        .level_out   (pin_level),
        .cond_out    (irq_cond)
    );

    // axi write channel: address and data taken in either order, one write at a time
    assign wr_fire = aw_hold_r & w_hold_r & ~bvalid_r;
    assign wen     = wr_fire & wstrb_r;
    assign wd      = wdata_r;
    assign wa      = {awaddr_r[11:2], 2'b00};

    always @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
            bvalid_r  <= 1'b0;
            bresp_r   <= `GPC_RESP_OKAY;
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            awaddr_r  <= 12'h000;
            wdata_r   <= 8'h00;
            wstrb_r   <= 1'b0;
        end else begin
            if (s_axi_awvalid && awready_r) begin
                aw_hold_r <= 1'b1;
                awready_r <= 1'b0;
                awaddr_r  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && wready_r) begin
                w_hold_r <= 1'b1;
                wready_r <= 1'b0;
                wdata_r  <= s_axi_wdata[7:0];
                wstrb_r  <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_hold_r <= 1'b0;
                w_hold_r  <= 1'b0;
                bvalid_r  <= 1'b1;
                bresp_r   <= wr_map_ok(wa) ? `GPC_RESP_OKAY : `GPC_RESP_SLVERR;
            end
            if (bvalid_r && s_axi_bready) begin
                bvalid_r  <= 1'b0;
                awready_r <= 1'b1;
                wready_r  <= 1'b1;
            end
        end
    end

    function wr_map_ok;
        input [11:0] a;
        begin
            wr_map_ok = (a[`GPC_DATA_TOP_BIT] == 2'b00) ||
                        (a >= `GPC_OFF_DIR && a <= `GPC_OFF_AFSEL && a != `GPC_OFF_IRAW &&
                         a != `GPC_OFF_IMSK_ST) ||
                        (a >= `GPC_OFF_DRV_LO && a <= `GPC_OFF_COMMIT);
        end
    endfunction

    // protection applies only to the debug pins; others always accept alt select writes
    assign prot     = PROT_MASK[W-1:0];
    assign afsel_ok = ~prot | (protect_commit_r & {W{~protect_lock_r}});
    assign clr_bits = (wen && wa == `GPC_OFF_ICLR) ? wd[W-1:0] : {W{1'b0}};

    // edge hits latch until cleared, a new hit in the clear cycle wins;
    // level hits follow the pin, so a clear has no effect and the bit drops once the level goes away
    always @* begin
        for (k = 0; k < W; k = k + 1) begin
            if (irq_sense_select_r[k]) begin
                ris_nxt[k] = irq_cond[k];
            end else begin
                ris_nxt[k] = irq_cond[k] | (irq_raw_status_r[k] & ~clr_bits[k]);
            end
        end
    end

    always @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            // one reset serves power-on and the reset pin alike
            pin_value_reg_r       <= `GPC_RST_ZERO;
            pin_direction_r       <= `GPC_RST_ZERO;
            irq_sense_select_r    <= `GPC_RST_ZERO;
            irq_both_edges_r      <= `GPC_RST_ZERO;
            irq_event_polarity_r  <= `GPC_RST_ZERO;
            irq_mask_r            <= `GPC_RST_ZERO;
            irq_raw_status_r      <= `GPC_RST_ZERO;
            alt_function_select_r <= PROT_MASK;
            digital_pad_enable_r  <= PROT_MASK;
            pull_up_select_r      <= PROT_MASK;
            pull_down_select_r    <= `GPC_RST_ZERO;
            drive_low_select_r    <= `GPC_RST_DRV_LO;
            drive_mid_select_r    <= `GPC_RST_ZERO;
            drive_high_select_r   <= `GPC_RST_ZERO;
            open_drain_select_r   <= `GPC_RST_ZERO;
            slew_control_select_r <= `GPC_RST_ZERO;
            protect_lock_r        <= 1'b1;
            protect_commit_r      <= ~PROT_MASK;
        end else begin
            irq_raw_status_r <= ris_nxt;
            for (kc = 0; kc < W; kc = kc + 1) begin
                if (!pin_direction_r[kc]) begin
                    pin_value_reg_r[kc] <= pin_level[kc] & digital_pad_enable_r[kc];
                end else if (wen && wa[`GPC_DATA_TOP_BIT] == 2'b00 && wa[kc+2]) begin
                    pin_value_reg_r[kc] <= wd[kc];
                end
            end
            if (wen) begin
                case (wa)
                    `GPC_OFF_DIR: begin
                        pin_direction_r <= wd[W-1:0];
                    end
                    `GPC_OFF_ISENSE: begin
                        irq_sense_select_r <= wd[W-1:0];
                    end
                    `GPC_OFF_IBOTH: begin
                        irq_both_edges_r <= wd[W-1:0];
                    end
                    `GPC_OFF_IEVENT: begin
                        irq_event_polarity_r <= wd[W-1:0];
                    end
                    `GPC_OFF_IMASK: begin
                        irq_mask_r <= wd[W-1:0];
                    end
                    `GPC_OFF_AFSEL: begin
                        alt_function_select_r <= (wd[W-1:0] & afsel_ok) |
                                                 (alt_function_select_r & ~afsel_ok);
                    end
                    // one drive strength per pin: picking one drops the other two
                    `GPC_OFF_DRV_LO: begin
                        drive_low_select_r  <= wd[W-1:0];
                        drive_mid_select_r  <= drive_mid_select_r & ~wd[W-1:0];
                        drive_high_select_r <= drive_high_select_r & ~wd[W-1:0];
                    end
                    `GPC_OFF_DRV_MID: begin
                        drive_mid_select_r  <= wd[W-1:0];
                        drive_low_select_r  <= drive_low_select_r & ~wd[W-1:0];
                        drive_high_select_r <= drive_high_select_r & ~wd[W-1:0];
                    end
                    `GPC_OFF_DRV_HI: begin
                        drive_high_select_r <= wd[W-1:0];
                        drive_low_select_r  <= drive_low_select_r & ~wd[W-1:0];
                        drive_mid_select_r  <= drive_mid_select_r & ~wd[W-1:0];
                    end
                    `GPC_OFF_ODRAIN: begin
                        open_drain_select_r <= wd[W-1:0];
                    end
                    `GPC_OFF_PULLUP: begin
                        pull_up_select_r <= wd[W-1:0];
                    end
                    `GPC_OFF_PULLDN: begin
                        pull_down_select_r <= wd[W-1:0];
                    end
                    `GPC_OFF_SLEW: begin
                        slew_control_select_r <= wd[W-1:0];
                    end
                    `GPC_OFF_DEN: begin
                        digital_pad_enable_r <= wd[W-1:0];
                    end
                    `GPC_OFF_COMMIT: begin
                        if (!protect_lock_r) begin
                            protect_commit_r <= (wd[W-1:0] & prot) | ~prot;
                        end
                    end
                    default: begin
                    end
                endcase
            end
            // key compares the low byte only since the bus keeps just wdata[7:0]
            if (wen && wa == `GPC_OFF_LOCK) begin
                protect_lock_r <= (wd != LOCK_KEY[7:0]);
            end
        end
    end

    // pin drive: alternate function or software, open drain only pulls low
    always @* begin
        for (kd = 0; kd < W; kd = kd + 1) begin
            if (alt_function_select_r[kd]) begin
                drv_val[kd] = alt_out_in[kd];
                drv_en[kd]  = alt_oe_in[kd];
            end else begin
                drv_val[kd] = pin_value_reg_r[kd];
                drv_en[kd]  = pin_direction_r[kd];
            end
            drv_en[kd] = drv_en[kd] & digital_pad_enable_r[kd];
            if (open_drain_select_r[kd]) begin
                drv_en[kd]  = drv_en[kd] & ~drv_val[kd];
                drv_val[kd] = 1'b0;
            end
        end
    end

    always @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pin_out_r  <= {W{1'b0}};
            pin_oe_n_r <= {W{1'b1}};
            alt_in_r   <= {W{1'b0}};
            irq_r      <= 1'b0;
        end else begin
            pin_out_r  <= drv_val;
            pin_oe_n_r <= ~drv_en;
            alt_in_r   <= pin_level & digital_pad_enable_r;
            irq_r      <= |(ris_nxt & irq_mask_r);
        end
    end

    // read decode
    always @* begin
        rd_byte = 8'h00;
        rd_err  = 1'b0;
        id_off  = s_axi_araddr - `GPC_OFF_ID_BASE;
        id_byte = 8'h00;
        if (id_off[5:2] < 4'h8) begin
            id_byte = PERIPH_ID[{id_off[4:2], 3'b000} +: 8];
        end else begin
            id_byte = CELL_ID[{id_off[3:2], 3'b000} +: 8];
        end
        if (s_axi_araddr[`GPC_DATA_TOP_BIT] == 2'b00) begin
            rd_byte = pin_value_reg_r & s_axi_araddr[9:2];
        end else if (s_axi_araddr >= `GPC_OFF_ID_BASE && id_off[5:2] < `GPC_ID_WORDS) begin
            rd_byte = id_byte;
        end else begin
            case ({s_axi_araddr[11:2], 2'b00})
                `GPC_OFF_DIR:     rd_byte = pin_direction_r;
                `GPC_OFF_ISENSE:  rd_byte = irq_sense_select_r;
                `GPC_OFF_IBOTH:   rd_byte = irq_both_edges_r;
                `GPC_OFF_IEVENT:  rd_byte = irq_event_polarity_r;
                `GPC_OFF_IMASK:   rd_byte = irq_mask_r;
                `GPC_OFF_IRAW:    rd_byte = irq_raw_status_r;
                `GPC_OFF_IMSK_ST: rd_byte = irq_raw_status_r & irq_mask_r;
                `GPC_OFF_ICLR:    rd_byte = 8'h00;
                `GPC_OFF_AFSEL:   rd_byte = alt_function_select_r;
                `GPC_OFF_DRV_LO:  rd_byte = drive_low_select_r;
                `GPC_OFF_DRV_MID: rd_byte = drive_mid_select_r;
                `GPC_OFF_DRV_HI:  rd_byte = drive_high_select_r;
                `GPC_OFF_ODRAIN:  rd_byte = open_drain_select_r;
                `GPC_OFF_PULLUP:  rd_byte = pull_up_select_r;
                `GPC_OFF_PULLDN:  rd_byte = pull_down_select_r;
                `GPC_OFF_SLEW:    rd_byte = slew_control_select_r;
                `GPC_OFF_DEN:     rd_byte = digital_pad_enable_r;
                `GPC_OFF_LOCK:    rd_byte = {7'h00, protect_lock_r};
                `GPC_OFF_COMMIT:  rd_byte = protect_commit_r;
                default:          rd_err  = 1'b1;
            endcase
        end
    end

    // axi read channel: answer one cycle after the address is taken
    always @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h0000_0000;
            rresp_r   <= `GPC_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && arready_r) begin
                arready_r <= 1'b0;
                rvalid_r  <= 1'b1;
                rdata_r   <= {24'h00_0000, rd_byte};
                rresp_r   <= rd_err ? `GPC_RESP_SLVERR : `GPC_RESP_OKAY;
            end
            if (rvalid_r && s_axi_rready) begin
                rvalid_r  <= 1'b0;
                arready_r <= 1'b1;
            end
        end
    end

    assign s_axi_awready          = awready_r;
    assign s_axi_wready           = wready_r;
    assign s_axi_bvalid           = bvalid_r;
    assign s_axi_bresp            = bresp_r;
    assign s_axi_arready          = arready_r;
    assign s_axi_rvalid           = rvalid_r;
    assign s_axi_rdata            = rdata_r;
    assign s_axi_rresp            = rresp_r;
    assign pin_out                = pin_out_r;
    assign pin_oe_n_out           = pin_oe_n_r;
    assign alt_in_out             = alt_in_r;
    assign pull_up_out            = pull_up_select_r;
    assign pull_down_out          = pull_down_select_r;
    assign drive_low_out          = drive_low_select_r;
    assign drive_mid_out          = drive_mid_select_r;
    assign drive_high_out         = drive_high_select_r;
    assign slew_out               = slew_control_select_r;
    assign digital_pad_enable_out = digital_pad_enable_r;
    assign irq_out                = irq_r;

endmodule

// ===== gpc_port_monitor.sv
`timescale 1ns/10ps
module gpc_port_monitor #(parameter [7:0] PROT_MASK = 8'h00) (
    // watched ports
    input wire        core_clk_in, rstn_in, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
    input wire        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
    input wire        irq_out,
    input wire [1:0]  s_axi_bresp,
    input wire [31:0] s_axi_rdata,
    input wire [7:0]  pin_oe_n_out, pull_up_out, pull_down_out, digital_pad_enable_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rstn_in);
    a_reset_pads: assert property (
        $rose(rstn_in) |-> pull_up_out == PROT_MASK && digital_pad_enable_out == PROT_MASK && pull_down_out == 8'h00)
        else $error("pad defaults wrong after reset");
    // protected bits may already follow the peripheral, so only ordinary bits are judged
    a_reset_float: assert property (
        $rose(rstn_in) |-> !irq_out && (pin_oe_n_out | PROT_MASK) == 8'hFF)
        else $error("pins driven after reset");
    a_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_aw_blocked: assert property (
        s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("second write address accepted");
    a_b_stands: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_r_stands: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_rdata_byte: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000 && !s_axi_arready)
        else $error("read word malformed");
    cover property (s_axi_bvalid && s_axi_bready);
    cover property (s_axi_rvalid && s_axi_rready);
    cover property ($rose(irq_out));
endmodule
bind gpc_port gpc_port_monitor #(.PROT_MASK(PROT_MASK)) u_mon (.core_clk_in, .rstn_in, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rready, .irq_out, .s_axi_bresp, .s_axi_rdata, .pin_oe_n_out, .pull_up_out,
    .pull_down_out, .digital_pad_enable_out);

// ===== gpc_pin_partner.sv
`timescale 1ns/10ps
module gpc_pin_partner (
    // pad side of the port
    input  wire [7:0] pin_out_in, oe_n_in, pu_in, pd_in,
    // outside world
    input  wire       clk_in,
    input  wire [7:0] ext_en_in, ext_val_in,
    output logic [7:0] pin_in_out
);
    logic flt_r = 1'b0;
    // an undriven pad without pulls wanders instead of holding a stale level
    always @(posedge clk_in) flt_r <= ~flt_r;
    always_comb
        for (int i = 0; i < 8; i++)
            pin_in_out[i] = !oe_n_in[i] ? pin_out_in[i] : ext_en_in[i] ? ext_val_in[i] :
                            pu_in[i] ? 1'b1 : pd_in[i] ? 1'b0 : flt_r;
endmodule

// ===== gpc_port_tb.sv
`timescale 1ns/10ps
module gpc_port_tb;
    logic        core_clk_in, rstn_in, awv, wv, brd, arv, rrd;
    logic [11:0] awa, ara;
    logic [31:0] wd;
    logic [7:0]  ext_en, ext_val, alt_out, alt_oe;
    wire         awr, wr_, bv, arr, rv, irq;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    wire  [7:0]  pin_in, pin_out, oe_n, alt_in, pu, pd, den;
    integer      n_errors = 0, total_checks = 0;
    gpc_port #(.PROT_MASK(8'h80)) uut (.core_clk_in(core_clk_in), .rstn_in(rstn_in), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(brd), .s_axi_bresp(bresp), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rrd), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n_out(oe_n), .alt_out_in(alt_out),
        .alt_oe_in(alt_oe), .alt_in_out(alt_in), .pull_up_out(pu), .pull_down_out(pd), .drive_low_out(),
        .drive_mid_out(), .drive_high_out(), .slew_out(), .digital_pad_enable_out(den), .irq_out(irq));
    gpc_pin_partner pins (.pin_out_in(pin_out), .oe_n_in(oe_n), .pu_in(pu), .pd_in(pd), .clk_in(core_clk_in),
        .ext_en_in(ext_en), .ext_val_in(ext_val), .pin_in_out(pin_in));
    task chk(input [31:0] got, input [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // only the watchdog ends a wait whose answer never comes
    task wr(input [11:0] a, input [31:0] d, input [1:0] er);
        @(posedge core_clk_in);
        {awv, wv, brd} <= 3'h7;
        awa <= a;
        wd <= d;
        do begin
            @(posedge core_clk_in);
            if (awr) awv <= 1'b0;
            if (wr_) wv <= 1'b0;
        end while (bv !== 1'b1);
        brd <= 1'b0;
        chk(bresp, er);
    endtask
    task rd(input [11:0] a, input [31:0] e, input [1:0] er);
        @(posedge core_clk_in);
        {arv, rrd} <= 2'h3;
        ara <= a;
        do begin
            @(posedge core_clk_in);
            if (arr) arv <= 1'b0;
        end while (rv !== 1'b1);
        rrd <= 1'b0;
        chk(rdata, e);
        chk(rresp, er);
    endtask
    task report_and_stop;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        core_clk_in = 1'b0;
        forever #50 core_clk_in = ~core_clk_in;
    end
    initial begin
        #2000000;
        n_errors++;
        report_and_stop;
    end
    initial begin
        {rstn_in, awv, wv, brd, arv, rrd, awa, ara, wd} = 0;
        {ext_en, ext_val, alt_out, alt_oe} = 32'hFF00_8080;
        repeat (20) @(posedge core_clk_in);
        rstn_in <= 1'b1;
        repeat (3) @(posedge core_clk_in);
        rd(12'h420, 8'h80, 0);
        rd(12'h510, 8'h80, 0);
        rd(12'h51C, 8'h80, 0);
        rd(12'h514, 8'h00, 0);
        rd(12'h500, 8'hFF, 0);
        rd(12'h524, 8'h7F, 0);
        rd(12'hFD0, 8'h00, 0);
        rd(12'hFFC, 8'h00, 0);
        rd(12'h600, 8'h00, 2);
        chk({oe_n, pin_out, alt_in}, 24'h7F8080);
        $display("reset test done");
        wr(12'h51C, 8'hFF, 0);
        wr(12'h400, 8'hFF, 0);
        wr(12'h098, 8'hEB, 0);
        rd(12'h1FC, 8'h22, 0);
        rd(12'h0C4, 8'h20, 0);
        repeat (3) @(posedge core_clk_in);
        chk({oe_n, pin_out}, 16'h00A2);
        wr(12'h008, 8'h00, 0);
        rd(12'h1FC, 8'h20, 0);
        wr(12'h400, 8'h00, 0);
        ext_val <= 8'h5A;
        repeat (8) @(posedge core_clk_in);
        rd(12'h1FC, 8'h5A, 0);
        $display("data test done");
        // the data test toggled pins, so falling edges are already latched
        wr(12'h41C, 8'hFF, 0);
        wr(12'h408, 8'h02, 0);
        wr(12'h40C, 8'h01, 0);
        wr(12'h410, 8'h03, 0);
        ext_val <= 8'h5B;
        repeat (8) @(posedge core_clk_in);
        rd(12'h414, 8'h01, 0);
        chk(irq, 1);
        ext_val <= 8'h58;
        repeat (8) @(posedge core_clk_in);
        rd(12'h414, 8'h03, 0);
        wr(12'h410, 8'h01, 0);
        rd(12'h418, 8'h01, 0);
        wr(12'h41C, 8'h00, 0);
        rd(12'h414, 8'h03, 0);
        wr(12'h41C, 8'h03, 0);
        rd(12'h414, 8'h00, 0);
        chk(irq, 0);
        wr(12'h414, 8'hFF, 2);
        wr(12'h410, 8'h00, 0);
        wr(12'h404, 8'h04, 0);
        wr(12'h40C, 8'h05, 0);
        ext_val <= 8'h5C;
        repeat (8) @(posedge core_clk_in);
        wr(12'h410, 8'h04, 0);
        rd(12'h418, 8'h04, 0);
        chk(irq, 1);
        ext_val <= 8'h58;
        repeat (8) @(posedge core_clk_in);
        rd(12'h414, 8'h00, 0);
        chk(irq, 0);
        $display("interrupt test done");
        wr(12'h420, 8'h01, 0);
        rd(12'h420, 8'h81, 0);
        wr(12'h520, 8'h5A, 0);
        wr(12'h524, 8'h80, 0);
        wr(12'h420, 8'h00, 0);
        rd(12'h420, 8'h00, 0);
        rstn_in <= 1'b0;
        repeat (3) @(posedge core_clk_in);
        rstn_in <= 1'b1;
        rd(12'h420, 8'h80, 0);
        chk({pu, pd, den}, 24'h800080);
        $display("protect test done");
        report_and_stop;
    end
endmodule
